//--- rtl/nv_pkg.sv
// Shared constants and types for the nonvolatile data access controller
package nv_pkg;
  localparam int unsigned NV_ADDR_W = 9;
  localparam int unsigned IO_ADDR_W = 7;
  localparam logic [6:0] IO_ADDR_HIGH = 7'h10;
  localparam logic [6:0] IO_ADDR_LOW = 7'h11;
  localparam logic [6:0] IO_DATA = 7'h12;
  localparam logic [6:0] IO_CTRL = 7'h13;
  localparam logic [6:0] IO_LAST = 7'h3f;
  localparam logic [6:0] IO_BIT_LAST = 7'h1f;
  localparam logic [6:0] DATA_SPACE_BASE = 7'h20;
  localparam logic [6:0] DATA_SPACE_LAST = 7'h5f;
  localparam int unsigned RS_BIT = 0;
  localparam int unsigned WS_BIT = 1;
  localparam int unsigned MWE_BIT = 2;
  localparam int unsigned RIE_BIT = 3;
  localparam logic [8:0] ADDR_RESET = 9'h000;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [2:0] MWE_WINDOW = 3'h4;
  localparam logic [2:0] READ_STALL = 3'h4;
  localparam logic [2:0] WRITE_STALL = 3'h2;
  localparam int unsigned OSC_FREQ_KHZ = 1000;
  localparam int unsigned WRITE_OSC_CYCLES = 8448;
  localparam int unsigned CORE_FREQ_MHZ = 250;
  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_ADDR_HIGH = 3'b001,
    SEL_ADDR_LOW = 3'b010,
    SEL_DATA = 3'b011,
    SEL_CTRL = 3'b100
  } reg_sel_type;
  typedef enum logic {
    TMR_IDLE = 1'b0,
    TMR_BUSY = 1'b1
  } timer_state_type;
endpackage

//--- rtl/write_timer_if.sv
// Handshake between the register logic and the write interval timer
`timescale 1ns/1ps
interface write_timer_if;
  logic start;
  logic busy;
  modport ctrl (output start, input busy);
  modport timer (input start, output busy);
endinterface

//--- rtl/nv_write_timer.sv
// Self-timed write interval counted in RC oscillator ticks
`timescale 1ns/1ps
module nv_write_timer #(
  parameter int unsigned OSC_CYCLES = nv_pkg::WRITE_OSC_CYCLES
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_supply_ok,
  input wire logic i_osc_tick,
  write_timer_if.timer tmr
);
  localparam int unsigned CW = $clog2(OSC_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(OSC_CYCLES - 1);
  nv_pkg::timer_state_type state_q;
  logic [CW-1:0] cnt_q;

  // Reset spares a running write
  // Only a reset with a failing supply aborts the interval
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn && !i_supply_ok) begin
      state_q <= nv_pkg::TMR_IDLE;
    end else begin
      unique case (state_q)
        nv_pkg::TMR_IDLE: begin
          if (tmr.start) begin
            state_q <= nv_pkg::TMR_BUSY;
          end
        end
        nv_pkg::TMR_BUSY: begin
          if (i_osc_tick && cnt_q == LAST) begin
            state_q <= nv_pkg::TMR_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn && !i_supply_ok) begin
      cnt_q <= '0;
    end else if (state_q == nv_pkg::TMR_IDLE) begin
      cnt_q <= '0;
    end else if (i_osc_tick) begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  assign tmr.busy = (state_q == nv_pkg::TMR_BUSY);
endmodule

//--- rtl/eeprom_access_controller.sv
// I/O register front end for the on-chip nonvolatile data array
`timescale 1ns/1ps
module eeprom_access_controller #(
  parameter int unsigned WRITE_OSC_CYCLES = nv_pkg::WRITE_OSC_CYCLES
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_supply_ok,
  input wire logic i_osc_tick,
  input wire logic [6:0] i_addr,
  input wire logic i_io_space,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wdata,
  input wire logic i_bit_set,
  input wire logic i_bit_clr,
  input wire logic [2:0] i_bit_num,
  input wire logic i_global_irq_en,
  input wire logic i_self_program_busy,
  input wire logic [7:0] i_nv_rdata,
  output logic [7:0] o_rd_data,
  output logic o_irq_req,
  output logic o_cpu_stall,
  output logic [8:0] o_nv_addr,
  output logic [7:0] o_nv_wdata,
  output logic o_nv_write,
  output logic o_write_busy
);
  logic [8:0] addr_q;
  logic [7:0] data_q;
  logic rie_q;
  logic mwe_q;
  logic [2:0] mwe_cnt_q;
  logic [2:0] stall_cnt_q;
  logic stall_q;
  logic irq_q;
  logic [7:0] rdata_q;
  logic [7:0] wdata_q;
  logic nv_write_q;
  logic busy;
  logic bit_op;
  logic bit_ok;
  logic wr_en;
  logic [7:0] wr_val;
  logic [7:0] bit_cur;
  nv_pkg::reg_sel_type wr_sel;
  nv_pkg::reg_sel_type rd_sel;
  logic ctrl_wr;
  logic launch;
  logic rd_launch;

  write_timer_if tmr ();

  nv_write_timer #(
    .OSC_CYCLES(WRITE_OSC_CYCLES)
  ) u_timer (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_supply_ok(i_supply_ok),
    .i_osc_tick(i_osc_tick),
    .tmr(tmr.timer)
  );

  assign busy = tmr.busy;

  function automatic nv_pkg::reg_sel_type reg_sel(
    input logic [6:0] addr,
    input logic io_space
  );
    logic [6:0] io;
    logic hit;
    io = io_space ? addr : 7'(addr - nv_pkg::DATA_SPACE_BASE);
    hit = io_space ? (addr <= nv_pkg::IO_LAST)
                   : (addr >= nv_pkg::DATA_SPACE_BASE &&
                      addr <= nv_pkg::DATA_SPACE_LAST);
    reg_sel = nv_pkg::SEL_NONE;
    if (hit) begin
      unique case (io)
        nv_pkg::IO_ADDR_HIGH: reg_sel = nv_pkg::SEL_ADDR_HIGH;
        nv_pkg::IO_ADDR_LOW: reg_sel = nv_pkg::SEL_ADDR_LOW;
        nv_pkg::IO_DATA: reg_sel = nv_pkg::SEL_DATA;
        nv_pkg::IO_CTRL: reg_sel = nv_pkg::SEL_CTRL;
        default: reg_sel = nv_pkg::SEL_NONE;
      endcase
    end
  endfunction

  function automatic logic [7:0] read_val(
    input nv_pkg::reg_sel_type sel,
    input logic [8:0] addr,
    input logic [7:0] data,
    input logic rie,
    input logic mwe,
    input logic ws
  );
    read_val = 8'h00;
    unique case (sel)
      nv_pkg::SEL_ADDR_HIGH: read_val = {7'h00, addr[8]};
      nv_pkg::SEL_ADDR_LOW: read_val = addr[7:0];
      nv_pkg::SEL_DATA: read_val = data;
      nv_pkg::SEL_CTRL: read_val = {4'h0, rie, mwe, ws, 1'b0};
      default: read_val = 8'h00;
    endcase
  endfunction

  assign wr_sel = reg_sel(i_addr, i_io_space);
  assign rd_sel = reg_sel(i_addr, i_io_space);
  assign bit_op = i_bit_set | i_bit_clr;
  assign bit_ok = i_io_space && (i_addr <= nv_pkg::IO_BIT_LAST);
  assign bit_cur = read_val(wr_sel, addr_q, data_q, rie_q, mwe_q, busy);

  // Bit instructions rewrite the whole register from its read value
  always_comb begin
    wr_val = i_wdata;
    if (!i_wr) begin
      wr_val = bit_cur;
      wr_val[i_bit_num] = i_bit_set;
    end
  end

  assign wr_en = i_wr | (bit_op & bit_ok);
  assign ctrl_wr = wr_en && (wr_sel == nv_pkg::SEL_CTRL);

  assign launch = ctrl_wr && wr_val[nv_pkg::WS_BIT] && mwe_q &&
                  !busy && !i_self_program_busy;
  assign rd_launch = ctrl_wr && wr_val[nv_pkg::RS_BIT] && !busy && !launch;
  assign tmr.start = launch;

  // Software may not rely on this value
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      addr_q <= nv_pkg::ADDR_RESET;
    end else if (wr_en && !busy) begin
      if (wr_sel == nv_pkg::SEL_ADDR_HIGH) begin
        addr_q[8] <= wr_val[0];
      end else if (wr_sel == nv_pkg::SEL_ADDR_LOW) begin
        addr_q[7:0] <= wr_val;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      data_q <= nv_pkg::DATA_RESET;
    end else if (rd_launch) begin
      data_q <= i_nv_rdata;
    end else if (wr_en && wr_sel == nv_pkg::SEL_DATA) begin
      data_q <= wr_val;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      rie_q <= 1'b0;
    end else if (ctrl_wr) begin
      rie_q <= wr_val[nv_pkg::RIE_BIT];
    end
  end

  // Window counted in core clocks
  // A rewrite of one while armed keeps the window, so a bit-set of the
  // strobe cannot stretch it
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      mwe_q <= 1'b0;
      mwe_cnt_q <= 3'h0;
    end else if (ctrl_wr && !wr_val[nv_pkg::MWE_BIT]) begin
      mwe_q <= 1'b0;
      mwe_cnt_q <= 3'h0;
    end else if (ctrl_wr && !mwe_q) begin
      mwe_q <= 1'b1;
      mwe_cnt_q <= 3'h0;
    end else if (mwe_q) begin
      if (mwe_cnt_q == 3'(nv_pkg::MWE_WINDOW - 3'h1)) begin
        mwe_q <= 1'b0;
        mwe_cnt_q <= 3'h0;
      end else begin
        mwe_cnt_q <= mwe_cnt_q + 3'h1;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      stall_cnt_q <= 3'h0;
      stall_q <= 1'b0;
    end else if (launch) begin
      stall_cnt_q <= nv_pkg::WRITE_STALL;
      stall_q <= 1'b1;
    end else if (rd_launch) begin
      stall_cnt_q <= nv_pkg::READ_STALL;
      stall_q <= 1'b1;
    end else if (stall_cnt_q != 3'h0) begin
      stall_cnt_q <= stall_cnt_q - 3'h1;
      stall_q <= (stall_cnt_q > 3'h1);
    end else begin
      stall_q <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= rie_q && i_global_irq_en && !busy;
    end
  end

  // Read data registered; one cycle after the read request
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      rdata_q <= 8'h00;
    end else if (i_rd) begin
      rdata_q <= read_val(rd_sel, addr_q, data_q, rie_q, mwe_q, busy);
    end
  end

  // Write data latched at launch
  // Latching protects the array from later data register writes
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      wdata_q <= nv_pkg::DATA_RESET;
      nv_write_q <= 1'b0;
    end else begin
      nv_write_q <= launch;
      if (launch) begin
        wdata_q <= data_q;
      end
    end
  end

  assign o_rd_data = rdata_q;
  assign o_irq_req = irq_q;
  assign o_cpu_stall = stall_q;
  assign o_nv_addr = addr_q;
  assign o_nv_wdata = wdata_q;
  assign o_nv_write = nv_write_q;
  assign o_write_busy = busy;

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);

  mwe_expire_a: assert property (
    $rose(mwe_q) |-> ##4 !mwe_q
  ) else $error("master enable not cleared after four cycles");

  mwe_hold_a: assert property (
    $rose(mwe_q) && !ctrl_wr |=> mwe_q or ctrl_wr
  ) else $error("master enable dropped early");

  launch_gate_a: assert property (
    tmr.start |-> mwe_q && !busy
  ) else $error("write launched without master enable");

  no_launch_a: assert property (
    ctrl_wr && wr_val[nv_pkg::WS_BIT] && !mwe_q && !busy
    |=> !busy
  ) else $error("write started with master enable low");

  busy_hold_a: assert property (
    launch |=> busy [*8]
  ) else $error("strobe bit dropped early");

  write_stall_a: assert property (
    launch |=> o_cpu_stall [*2] ##1 !o_cpu_stall
  ) else $error("write stall length wrong");

  read_stall_a: assert property (
    rd_launch |=> o_cpu_stall [*4] ##1 !o_cpu_stall
  ) else $error("read stall length wrong");

  read_data_a: assert property (
    rd_launch |=> data_q == $past(i_nv_rdata)
  ) else $error("read byte not captured");

  addr_lock_a: assert property (
    busy && $past(busy) |-> $stable(addr_q)
  ) else $error("address changed during write");

  irq_level_a: assert property (
    rie_q && i_global_irq_en && !busy |=> o_irq_req
  ) else $error("ready interrupt missing");

  reserved_zero_a: assert property (
    i_rd && rd_sel inside {nv_pkg::SEL_ADDR_HIGH, nv_pkg::SEL_CTRL}
    |=> o_rd_data[7:4] == 4'h0
  ) else $error("reserved bits read nonzero");

  flash_block_a: assert property (
    i_self_program_busy |-> !tmr.start
  ) else $error("write launched during flash programming");

  bit_range_a: assert property (
    !i_wr && bit_op && !bit_ok |-> !wr_en
  ) else $error("bit access outside low range");

  write_cov: cover property (
    $rose(mwe_q) ##[1:4] launch
  );
  read_cov: cover property (
    rd_launch ##1 o_cpu_stall
  );
  expire_cov: cover property (
    $rose(mwe_q) ##4 !mwe_q && !busy
  );
  irq_cov: cover property (
    $fell(busy) ##1 o_irq_req
  );
endmodule

//--- bench/nv_array_model.sv
// Behavioural model of the 512-byte nonvolatile array
`timescale 1ns/1ps
module nv_array_model (
  input wire logic i_core_clk,
  input wire logic [8:0] i_nv_addr,
  input wire logic [7:0] i_nv_wdata,
  input wire logic i_nv_write,
  output logic [7:0] o_nv_rdata
);
  logic [7:0] mem_q [512];
  // Preset pattern so untouched cells are predictable
  initial begin
    for (int i = 0; i < 512; i++) begin
      mem_q[i] = 8'(i) ^ 8'hc3;
    end
  end
  always @(posedge i_core_clk) begin
    if (i_nv_write === 1'b1) begin
      mem_q[i_nv_addr] <= i_nv_wdata;
    end
  end
  assign o_nv_rdata = mem_q[i_nv_addr];
endmodule

//--- bench/test_eeprom_access_controller.sv
// Self-checking bench for the nonvolatile access controller
`timescale 1ns/1ps
module test_eeprom_access_controller;
  localparam int unsigned OSC_N = 8;
  localparam logic [6:0] A_HI = nv_pkg::IO_ADDR_HIGH;
  localparam logic [6:0] A_LO = nv_pkg::IO_ADDR_LOW;
  localparam logic [6:0] DAT = nv_pkg::IO_DATA;
  localparam logic [6:0] CTL = nv_pkg::IO_CTRL;
  localparam logic [6:0] DS = nv_pkg::DATA_SPACE_BASE;
  logic i_core_clk = 1'b0;
  logic i_resetn = 1'b0;
  // Supply reads low through the first reset so the write timer starts idle
  logic i_supply_ok = 1'b0;
  logic i_osc_tick = 1'b0;
  logic [6:0] i_addr = 7'h00;
  logic i_io_space = 1'b1;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] i_wdata = 8'h00;
  logic i_bit_set = 1'b0;
  logic i_bit_clr = 1'b0;
  logic [2:0] i_bit_num = 3'h0;
  logic i_global_irq_en = 1'b0;
  logic i_self_program_busy = 1'b0;
  logic [7:0] i_nv_rdata;
  logic [7:0] o_rd_data;
  logic o_irq_req;
  logic o_cpu_stall;
  logic [8:0] o_nv_addr;
  logic [7:0] o_nv_wdata;
  logic o_nv_write;
  logic o_write_busy;
  int num_errors = 0;
  int total_checks = 0;
  int tick_cnt = 0;
  int busy_ticks = 0;

  eeprom_access_controller #(.WRITE_OSC_CYCLES(OSC_N)) dut (
    .i_core_clk, .i_resetn, .i_supply_ok, .i_osc_tick, .i_addr, .i_io_space,
    .i_wr, .i_rd, .i_wdata, .i_bit_set, .i_bit_clr, .i_bit_num, .i_global_irq_en,
    .i_self_program_busy, .i_nv_rdata, .o_rd_data, .o_irq_req, .o_cpu_stall,
    .o_nv_addr, .o_nv_wdata, .o_nv_write, .o_write_busy);

  nv_array_model model (.i_core_clk, .i_nv_addr(o_nv_addr), .i_nv_wdata(o_nv_wdata),
    .i_nv_write(o_nv_write), .o_nv_rdata(i_nv_rdata));

  always #2 i_core_clk = ~i_core_clk;

  // One tick per 250 core cycles gives the 1 MHz oscillator rate
  always @(negedge i_core_clk) begin
    tick_cnt <= (tick_cnt == 249) ? 0 : tick_cnt + 1;
    i_osc_tick <= (tick_cnt == 249);
  end

  // Ticks seen while busy; cleared between writes
  always @(posedge i_core_clk) begin
    busy_ticks <= o_write_busy ? busy_ticks + int'(i_osc_tick) : 0;
  end

  task automatic end_sim;
    if (num_errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge i_core_clk);
    i_addr = a;
    i_wdata = d;
    i_wr = 1'b1;
    @(negedge i_core_clk);
    i_wr = 1'b0;
  endtask

  task automatic rdc(input logic [6:0] a, input logic [7:0] exp);
    @(negedge i_core_clk);
    i_addr = a;
    i_rd = 1'b1;
    @(negedge i_core_clk);
    i_rd = 1'b0;
    chk(o_rd_data, exp);
  endtask

  task automatic bop(input logic [6:0] a, input int unsigned b, input logic s);
    @(negedge i_core_clk);
    i_addr = a;
    i_bit_num = 3'(b);
    i_bit_set = s;
    i_bit_clr = !s;
    @(negedge i_core_clk);
    i_bit_set = 1'b0;
    i_bit_clr = 1'b0;
  endtask

  task automatic wait_done;
    int n;
    n = 0;
    while (o_write_busy !== 1'b0 && n < 4000) begin
      @(negedge i_core_clk);
      n++;
    end
    if (n == 4000) begin
      num_errors++;
      end_sim();
    end
  endtask

  task automatic t_regs;
    wr(A_HI, 8'hff);
    rdc(A_HI, 8'h01);
    wr(A_LO, 8'ha5);
    chk(o_nv_addr, 16'h01a5);
    wr(CTL, 8'hf8);
    rdc(CTL, 8'h08);
    i_global_irq_en = 1'b1;
    repeat (2) @(negedge i_core_clk);
    chk(o_irq_req, 1'b1);
    i_global_irq_en = 1'b0;
    repeat (2) @(negedge i_core_clk);
    chk(o_irq_req, 1'b0);
  endtask

  task automatic t_write;
    i_global_irq_en = 1'b0;
    wr(DAT, 8'h3c);
    wr(CTL, 8'h0c);
    wr(CTL, 8'h0e);
    i_global_irq_en = 1'b1;
    chk({o_write_busy, o_nv_write, o_cpu_stall}, 3'h7);
    chk(o_nv_addr, 16'h01a5);
    chk(o_nv_wdata, 8'h3c);
    @(negedge i_core_clk);
    chk({o_nv_write, o_cpu_stall}, 2'h1);
    @(negedge i_core_clk);
    chk(o_cpu_stall, 1'b0);
    chk(o_irq_req, 1'b0);
    wr(A_LO, 8'h00);
    chk(o_nv_addr, 16'h01a5);
    rdc(CTL, 8'h0a);
    wr(CTL, 8'h09);
    chk(o_cpu_stall, 1'b0);
    wait_done();
    chk(busy_ticks, OSC_N);
    @(negedge i_core_clk);
    chk(o_irq_req, 1'b1);
    chk(model.mem_q[9'h1a5], 8'h3c);
    rdc(CTL, 8'h08);
    i_global_irq_en = 1'b0;
  endtask

  task automatic t_read;
    wr(A_LO, 8'h55);
    wr(CTL, 8'h01);
    for (int i = 0; i < 4; i++) begin
      chk(o_cpu_stall, 1'b1);
      @(negedge i_core_clk);
    end
    chk(o_cpu_stall, 1'b0);
    rdc(DAT, 8'h96);
  endtask

  task automatic t_guard;
    wr(CTL, 8'h02);
    chk(o_write_busy, 1'b0);
    wr(CTL, 8'h04);
    rdc(CTL, 8'h04);
    rdc(CTL, 8'h04);
    rdc(CTL, 8'h00);
    wr(CTL, 8'h02);
    chk(o_write_busy, 1'b0);
    i_self_program_busy = 1'b1;
    wr(CTL, 8'h04);
    wr(CTL, 8'h06);
    chk(o_write_busy, 1'b0);
    i_self_program_busy = 1'b0;
  endtask

  task automatic t_bits;
    i_io_space = 1'b0;
    wr(A_LO + DS, 8'h77);
    i_io_space = 1'b1;
    chk(o_nv_addr, 16'h0177);
    bop(CTL, nv_pkg::RIE_BIT, 1'b1);
    rdc(CTL, 8'h08);
    i_io_space = 1'b0;
    bop(CTL + DS, nv_pkg::RIE_BIT, 1'b0);
    i_io_space = 1'b1;
    rdc(CTL, 8'h08);
    bop(CTL, nv_pkg::RIE_BIT, 1'b0);
    rdc(CTL, 8'h00);
    bop(CTL, nv_pkg::MWE_BIT, 1'b1);
    bop(CTL, nv_pkg::WS_BIT, 1'b1);
    chk(o_write_busy, 1'b1);
    i_resetn = 1'b0;
    repeat (2) @(negedge i_core_clk);
    i_resetn = 1'b1;
    chk(o_write_busy, 1'b1);
    chk(o_nv_addr, 16'h0000);
    wait_done();
    chk(busy_ticks, OSC_N);
    chk(model.mem_q[9'h177], 8'h96);
  endtask

  // A reset with a failing supply is the only way to abort a write
  task automatic t_abort;
    bop(CTL, nv_pkg::MWE_BIT, 1'b1);
    bop(CTL, nv_pkg::WS_BIT, 1'b1);
    chk(o_write_busy, 1'b1);
    i_supply_ok = 1'b0;
    i_resetn = 1'b0;
    repeat (2) @(negedge i_core_clk);
    i_resetn = 1'b1;
    i_supply_ok = 1'b1;
    chk(o_write_busy, 1'b0);
    chk(o_cpu_stall, 1'b0);
  endtask

  initial begin
    repeat (10) @(negedge i_core_clk);
    i_resetn = 1'b1;
    i_supply_ok = 1'b1;
    t_regs();
    t_write();
    t_read();
    t_guard();
    t_bits();
    t_abort();
    end_sim();
  end
endmodule
